// *** verilog/ssc_pkg.sv ***
// shared constants, register map and state types for the scope shot capture block
package ssc_pkg;
  // sample format and stream figures
  localparam int          SAMP_W        = 14;          // nominal resolution
  localparam int          MAX_LEN       = 64000;       // largest shot, in samples
  localparam int          MAX_RATE_LOG  = 15;          // largest log2 reduction factor
  localparam longint      BASE_RATE_SPS = 2000000000;  // full input sample rate
  // register byte offsets
  localparam logic [7:0]  A_CTRL        = 8'h00;
  localparam logic [7:0]  A_RATE        = 8'h04;
  localparam logic [7:0]  A_LEN         = 8'h08;
  localparam logic [7:0]  A_EMA         = 8'h0C;
  localparam logic [7:0]  A_STAT        = 8'h10;
  localparam logic [7:0]  A_IRQ_STS     = 8'h14;
  localparam logic [7:0]  A_IRQ_MSK     = 8'h18;
  localparam logic [7:0]  A_BUF_ADDR    = 8'h1C;
  localparam logic [7:0]  A_BUF_DATA    = 8'h20;
  // control field positions
  localparam int          C_RUN         = 0;
  localparam int          C_SINGLE      = 1;
  localparam int          C_TRIG_EN     = 2;
  localparam int          C_DECIM       = 3;
  localparam int          C_EMA_EN      = 4;
  localparam int          C_EMA_RST     = 5;
  localparam int          C_SRC_SEL     = 6;
  localparam int          C_CHAN_EN     = 7;
  localparam int          C_RF_MODE     = 8;
  // interrupt bit positions
  localparam int          I_SHOT_DONE   = 0;
  localparam int          I_STOPPED     = 1;
  // values after reset and axi response codes
  localparam logic [8:0]  CTRL_RST      = 9'h080;      // averaging, channel enabled, run off
  localparam logic [15:0] LEN_RST       = 16'h0400;
  localparam logic [3:0]  RATE_RST      = 4'h0;
  localparam logic [3:0]  EMA_RST_VAL   = 4'h2;
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARM  = 2'b01,
    ST_CAPT = 2'b10
  } ssc_state_t;
endpackage : ssc_pkg

// *** verilog/ssc_top.sv ***
// scope shot capture: source select, rate reduction, shot buffer, shot averaging, axi4-lite
`timescale 1ns/10ps
`default_nettype none
module ssc_top
  import ssc_pkg::*;
#(
  parameter bit HAS_CH2 = 1'b1
) (
  // clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // sample streams, one sample per clock
  input  wire logic [SAMP_W-1:0]    in0_i,
  input  wire logic [SAMP_W-1:0]    in0_q,
  input  wire logic [SAMP_W-1:0]    in1_i,
  input  wire logic [SAMP_W-1:0]    in1_q,
  input  wire logic                 trig_in,
  // axi4-lite slave
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // events
  output logic                      irq
);

  localparam int ACC_W = SAMP_W + MAX_RATE_LOG + 1;

  typedef struct packed {
    ssc_state_t         st;
    logic               awrdy;
    logic               aw_got;
    logic [7:0]         aw_addr;
    logic               wrdy;
    logic               w_got;
    logic [31:0]        wdata;
    logic [3:0]         wstrb;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               arrdy;
    logic               rvalid;
    logic [31:0]        rdata;
    logic [1:0]         rresp;
    logic [8:0]         ctrl;
    logic               single_req;
    logic               ema_clr;
    logic [3:0]         rate;
    logic [15:0]        len;
    logic [3:0]         ema_k;
    logic [1:0]         irq_sts;
    logic [1:0]         irq_msk;
    logic               irq;
    logic [15:0]        buf_addr;
    logic [15:0]        shots;
    logic               have_prev;
    logic [14:0]        cnt;
    logic [15:0]        idx;
    logic [ACC_W-1:0]   acc_i;
    logic [ACC_W-1:0]   acc_q;
  } ssc_regs_t;

  ssc_regs_t r_q, r_d;

  // shot buffer: in-phase in the low half, quadrature in the high half
  logic [2*SAMP_W-1:0] shot_mem [MAX_LEN];
  logic                mem_we;
  logic [2*SAMP_W-1:0] mem_wd;
  logic [2*SAMP_W-1:0] mem_old;
  logic [2*SAMP_W-1:0] mem_rd;

  initial begin
    if (HAS_CH2 !== 1'b0 && HAS_CH2 !== 1'b1) $error("HAS_CH2 must be 0 or 1");
  end

  // byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) m[8*b +: 8] = nw[8*b +: 8];
    end
    return m;
  endfunction : merge

  // one ema step per trace; depth k gives time constant near 2^k shots
  function automatic logic [SAMP_W-1:0] ema(input logic [SAMP_W-1:0] old,
                                            input logic [SAMP_W-1:0] nw, input logic [3:0] k);
    logic signed [SAMP_W:0] diff;
    logic signed [SAMP_W:0] sum;
    diff = $signed({nw[SAMP_W-1], nw}) - $signed({old[SAMP_W-1], old});
    sum  = $signed({old[SAMP_W-1], old}) + (diff >>> k);
    return sum[SAMP_W-1:0];
  endfunction : ema

  assign mem_old = shot_mem[r_q.idx];
  assign mem_rd  = shot_mem[r_q.buf_addr];

  ////////////////////////////////////////////////////////////////////////////////
  // next-state logic
  logic [SAMP_W-1:0]  src_i, src_q, red_i, red_q;
  logic [ACC_W-1:0]   sum_i, sum_q, avg_i, avg_q;
  logic [14:0]        last_cnt;
  logic               smp_out, shot_done;
  logic [31:0]        wval, rval;
  logic               rerr;

  always_comb begin
    r_d = r_q;
    // second input only reachable when the option exists
    src_i = (r_q.ctrl[C_SRC_SEL] && HAS_CH2) ? in1_i : in0_i;
    src_q = (r_q.ctrl[C_SRC_SEL] && HAS_CH2) ? in1_q : in0_q;
    if (!r_q.ctrl[C_RF_MODE]) src_q = '0;
    last_cnt = 15'((32'd1 << r_q.rate) - 32'd1);
    sum_i = r_q.acc_i + ACC_W'($signed(src_i));
    sum_q = r_q.acc_q + ACC_W'($signed(src_q));
    avg_i = ACC_W'($signed(sum_i) >>> r_q.rate);
    avg_q = ACC_W'($signed(sum_q) >>> r_q.rate);
    smp_out = 1'b0;
    red_i = src_i;
    red_q = src_q;
    if (r_q.st == ST_CAPT) begin
      if (r_q.ctrl[C_DECIM]) begin
        smp_out = (r_q.cnt == '0);
      end else begin
        smp_out = (r_q.cnt == last_cnt);
        red_i = avg_i[SAMP_W-1:0];
        red_q = avg_q[SAMP_W-1:0];
      end
    end
    // shot averaging reads the previous shot at the same index
    mem_we = smp_out;
    mem_wd = {red_q, red_i};
    if (r_q.ctrl[C_EMA_EN] && r_q.have_prev) begin
      mem_wd = {ema(mem_old[2*SAMP_W-1:SAMP_W], red_q, r_q.ema_k),
                ema(mem_old[SAMP_W-1:0], red_i, r_q.ema_k)};
    end
    shot_done = smp_out && (r_q.idx == r_q.len - 16'h0001);

    // capture sequencer
    unique case (r_q.st)
      ST_IDLE: begin
        if ((r_q.ctrl[C_RUN] || r_q.single_req) && r_q.ctrl[C_CHAN_EN]) begin
          r_d.st = ST_ARM;
          r_d.single_req = 1'b0;
        end
      end
      ST_ARM: begin
        if (!r_q.ctrl[C_TRIG_EN] || trig_in) begin
          r_d.st = ST_CAPT;
        end
        r_d.cnt = '0;
        r_d.idx = '0;
        r_d.acc_i = '0;
        r_d.acc_q = '0;
      end
      ST_CAPT: begin
        r_d.cnt = (r_q.cnt == last_cnt) ? '0 : r_q.cnt + 15'h0001;
        r_d.acc_i = (r_q.cnt == last_cnt) ? '0 : sum_i;
        r_d.acc_q = (r_q.cnt == last_cnt) ? '0 : sum_q;
        if (smp_out) r_d.idx = r_q.idx + 16'h0001;
        if (shot_done) begin
          r_d.shots = r_q.shots + 16'h0001;
          r_d.have_prev = 1'b1;
          // run keeps going; a single shot or cleared run stops here
          r_d.st = r_q.ctrl[C_RUN] ? ST_ARM : ST_IDLE;
        end
      end
      default: r_d.st = ST_IDLE;
    endcase
    if (r_q.ema_clr) r_d.have_prev = 1'b0;
    r_d.ema_clr = 1'b0;

    // axi write: address and data taken in either order
    if (s_axi_awvalid && r_q.awrdy) begin
      r_d.awrdy = 1'b0;
      r_d.aw_got = 1'b1;
      r_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r_q.wrdy) begin
      r_d.wrdy = 1'b0;
      r_d.w_got = 1'b1;
      r_d.wdata = s_axi_wdata;
      r_d.wstrb = s_axi_wstrb;
    end
    if (r_q.bvalid && s_axi_bready) begin
      r_d.bvalid = 1'b0;
      r_d.awrdy = 1'b1;
      r_d.wrdy = 1'b1;
    end
    wval = '0;
    if (r_q.aw_got && r_q.w_got) begin
      r_d.aw_got = 1'b0;
      r_d.w_got = 1'b0;
      r_d.bvalid = 1'b1;
      r_d.bresp = RESP_OKAY;
      unique case (r_q.aw_addr)
        A_CTRL: begin
          wval = merge({23'h0, r_q.ctrl}, r_q.wdata, r_q.wstrb);
          r_d.ctrl = wval[8:0];
          r_d.ctrl[C_SINGLE] = 1'b0;
          r_d.ctrl[C_EMA_RST] = 1'b0;
          if (wval[C_SINGLE]) r_d.single_req = 1'b1;
          if (wval[C_EMA_RST]) r_d.ema_clr = 1'b1;
        end
        A_RATE: begin
          wval = merge({28'h0, r_q.rate}, r_q.wdata, r_q.wstrb);
          r_d.rate = wval[3:0];
        end
        A_LEN: begin
          wval = merge({16'h0, r_q.len}, r_q.wdata, r_q.wstrb);
          r_d.len = (wval[15:0] == '0) ? 16'h0001 :
                    (wval[15:0] > 16'(MAX_LEN)) ? 16'(MAX_LEN) : wval[15:0];
        end
        A_EMA: begin
          wval = merge({28'h0, r_q.ema_k}, r_q.wdata, r_q.wstrb);
          r_d.ema_k = wval[3:0];
        end
        A_IRQ_STS: begin
          wval = merge(32'h0, r_q.wdata, r_q.wstrb);
          r_d.irq_sts = r_q.irq_sts & ~wval[1:0];
        end
        A_IRQ_MSK: begin
          wval = merge({30'h0, r_q.irq_msk}, r_q.wdata, r_q.wstrb);
          r_d.irq_msk = wval[1:0];
        end
        A_BUF_ADDR: begin
          wval = merge({16'h0, r_q.buf_addr}, r_q.wdata, r_q.wstrb);
          r_d.buf_addr = (wval[15:0] >= 16'(MAX_LEN)) ? 16'(MAX_LEN - 1) : wval[15:0];
        end
        A_STAT, A_BUF_DATA: r_d.bresp = RESP_OKAY;
        default: r_d.bresp = RESP_SLVERR;
      endcase
    end

    // events set after the clear so a same-cycle event is kept
    if (shot_done) r_d.irq_sts[I_SHOT_DONE] = 1'b1;
    if (shot_done && !r_q.ctrl[C_RUN]) r_d.irq_sts[I_STOPPED] = 1'b1;
    r_d.irq = |(r_d.irq_sts & r_d.irq_msk);

    // axi read: one cycle from address to data
    rval = '0;
    rerr = 1'b0;
    unique case (s_axi_araddr)
      A_CTRL:     rval = {23'h0, r_q.ctrl};
      A_RATE:     rval = {28'h0, r_q.rate};
      A_LEN:      rval = {16'h0, r_q.len};
      A_EMA:      rval = {28'h0, r_q.ema_k};
      A_STAT:     rval = {r_q.shots, r_q.idx[13:0], r_q.st};
      A_IRQ_STS:  rval = {30'h0, r_q.irq_sts};
      A_IRQ_MSK:  rval = {30'h0, r_q.irq_msk};
      A_BUF_ADDR: rval = {16'h0, r_q.buf_addr};
      A_BUF_DATA: rval = {2'b00, mem_rd[2*SAMP_W-1:SAMP_W], 2'b00, mem_rd[SAMP_W-1:0]};
      default:    rerr = 1'b1;
    endcase
    if (s_axi_arvalid && r_q.arrdy) begin
      r_d.arrdy = 1'b0;
      r_d.rvalid = 1'b1;
      r_d.rdata = rval;
      r_d.rresp = rerr ? RESP_SLVERR : RESP_OKAY;
    end
    if (r_q.rvalid && s_axi_rready) begin
      r_d.rvalid = 1'b0;
      r_d.arrdy = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register; averaging mode and channel 1 enabled after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_q <= '0;
      r_q.st <= ST_IDLE;
      r_q.awrdy <= 1'b1;
      r_q.wrdy <= 1'b1;
      r_q.arrdy <= 1'b1;
      r_q.ctrl <= CTRL_RST;
      r_q.rate <= RATE_RST;
      r_q.len <= LEN_RST;
      r_q.ema_k <= EMA_RST_VAL;
    end else begin
      r_q <= r_d;
    end
  end

  // buffer write; no reset, contents are meaningless until a shot is stored
  always_ff @(posedge aclk) begin
    if (mem_we) shot_mem[r_q.idx] <= mem_wd;
  end

  assign s_axi_awready = r_q.awrdy;
  assign s_axi_wready  = r_q.wrdy;
  assign s_axi_bvalid  = r_q.bvalid;
  assign s_axi_bresp   = r_q.bresp;
  assign s_axi_arready = r_q.arrdy;
  assign s_axi_rvalid  = r_q.rvalid;
  assign s_axi_rdata   = r_q.rdata;
  assign s_axi_rresp   = r_q.rresp;
  assign irq           = r_q.irq;

  ////////////////////////////////////////////////////////////////////////////////
  // assertions
  AST_AVG_DEFAULT: assert property (@(posedge aclk) $rose(aresetn) |-> !r_q.ctrl[C_DECIM])
    else $error("averaging not default after reset");
  AST_DECIM_GAP: assert property (@(posedge aclk) disable iff (!aresetn)
    mem_we && r_q.ctrl[C_DECIM] && r_q.rate == 4'h2 && r_q.st == ST_CAPT && !shot_done
    |=> !mem_we [*3] ##1 mem_we)
    else $error("decimation by four spacing wrong");
  AST_LEN_BOUND: assert property (@(posedge aclk) disable iff (!aresetn)
    mem_we |-> r_q.idx < r_q.len && r_q.idx < 16'(MAX_LEN))
    else $error("write beyond shot length");
  AST_IDLE_QUIET: assert property (@(posedge aclk) disable iff (!aresetn)
    r_q.st != ST_CAPT |-> !mem_we)
    else $error("buffer written outside capture");
  AST_DONE_FLAG: assert property (@(posedge aclk) disable iff (!aresetn)
    shot_done |=> r_q.irq_sts[I_SHOT_DONE])
    else $error("shot done flag not set");
  AST_SINGLE_STOP: assert property (@(posedge aclk) disable iff (!aresetn)
    shot_done && !r_q.ctrl[C_RUN] |=> r_q.st == ST_IDLE)
    else $error("single shot did not stop");
  AST_RUN_REARM: assert property (@(posedge aclk) disable iff (!aresetn)
    shot_done && r_q.ctrl[C_RUN] |=> r_q.st == ST_ARM)
    else $error("run did not rearm");
  AST_FREE_RUN: assert property (@(posedge aclk) disable iff (!aresetn)
    r_q.st == ST_ARM && !r_q.ctrl[C_TRIG_EN] |=> r_q.st == ST_CAPT)
    else $error("continuous mode waited");
  AST_ACC_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
    r_q.st == ST_CAPT && $past(r_q.st) == ST_ARM |-> r_q.acc_i == '0 && r_q.cnt == '0)
    else $error("accumulator not cleared at shot start");
  AST_EMA_RESET: assert property (@(posedge aclk) disable iff (!aresetn)
    r_q.ema_clr && !shot_done |=> !r_q.have_prev)
    else $error("shot average not reset");
  AST_IRQ_LEVEL: assert property (@(posedge aclk) disable iff (!aresetn)
    irq == |(r_q.irq_sts & r_q.irq_msk))
    else $error("interrupt level wrong");
  COV_SHOT: cover property (@(posedge aclk) disable iff (!aresetn) shot_done);
  COV_TRIG: cover property (@(posedge aclk) disable iff (!aresetn)
    r_q.st == ST_ARM && r_q.ctrl[C_TRIG_EN] && trig_in);
  COV_EMA: cover property (@(posedge aclk) disable iff (!aresetn)
    mem_we && r_q.ctrl[C_EMA_EN] && r_q.have_prev);

endmodule : ssc_top
`default_nettype wire

// *** dv/ssc_src_model.sv ***
// sample stream model: the two digitised inputs feeding the capture block
`timescale 1ns/10ps
`default_nettype none
module ssc_src_model
  import ssc_pkg::*;
(
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // doubles the amplitude of every stream
  input  wire logic              big,
  // sample streams
  output logic [SAMP_W-1:0]      in0_i,
  output logic [SAMP_W-1:0]      in0_q,
  output logic [SAMP_W-1:0]      in1_i,
  output logic [SAMP_W-1:0]      in1_q
);
  logic ph_q;

  // phase toggles every clock, one new sample per clock at full rate
  always_ff @(posedge aclk) begin
    ph_q <= aresetn ? ~ph_q : 1'b0;
  end

  // two-level alternation: an even-length block mean does not depend on phase
  always_comb begin
    in0_i = (ph_q ? 14'h0300 : 14'h0100) << big;
    in0_q = 14'h0000 - in0_i;
    in1_i = (ph_q ? 14'h00C0 : 14'h0040) << big;
    in1_q = 14'h0000;
  end
endmodule : ssc_src_model
`default_nettype wire

// *** dv/testbench.sv ***
// self-checking testbench for the scope shot capture block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import ssc_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, trig_in = 1'b0, big = 1'b0;
  logic [SAMP_W-1:0] in0_i, in0_q, in1_i, in1_q;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp;
  int fail_count = 0, cmp_count = 0, cyc = 0;

  always #2 aclk = ~aclk;

  ssc_src_model src (.aclk(aclk), .aresetn(aresetn), .big(big), .in0_i(in0_i),
    .in0_q(in0_q), .in1_i(in1_i), .in1_q(in1_q));
  ssc_top uut (.aclk(aclk), .aresetn(aresetn), .in0_i(in0_i), .in0_q(in0_q),
    .in1_i(in1_i), .in1_q(in1_q), .trig_in(trig_in), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////
  // closing, comparison and hang guard
  task automatic end_sim();
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // every scenario together needs about a thousand cycles
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite master: hold each channel until taken, one edge gap afterwards
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(nm, d, exp);
  endtask : rd_chk

  // shot-done wait under a bound, then check that irq is up
  task automatic wait_shot();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 2000) begin
      @(posedge aclk);
      n++;
    end
    chk("irq after shot", {31'd0, irq}, 32'd1);
  endtask : wait_shot

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0]  r;
    rd_chk(A_CTRL, 32'h0000_0080, "ctrl reset");
    rd_chk(A_RATE, 32'h0000_0000, "rate reset");
    rd_chk(A_LEN, 32'h0000_0400, "len reset");
    rd_chk(A_EMA, 32'h0000_0002, "ema reset");
    rd_chk(A_IRQ_MSK, 32'h0000_0000, "mask reset");
    rd(8'h40, d, r);
    chk("unmapped resp", {30'd0, r}, {30'd0, RESP_SLVERR});
  endtask : t_reset

  // one single shot of 4 samples at N=4, every sample of the buffer judged
  task automatic t_shot(input logic [31:0] ctl, input logic [13:0] ei, input logic [13:0] eq,
                        input bit dec, input string nm);
    logic [31:0] d, first;
    logic [1:0]  r;
    wr(A_CTRL, ctl);
    wait_shot();
    wr(A_IRQ_STS, 32'h0000_0003);
    for (int k = 0; k < 4; k++) begin
      wr(A_BUF_ADDR, k);
      rd(A_BUF_DATA, d, r);
      if (k == 0) first = d;
      if (dec) begin
        chk(nm, d, first);
        chk(nm, {31'd0, d[13:0] == ei || d[13:0] == (ei << 1) + ei}, 32'd1);
      end else begin
        chk(nm, {18'd0, d[13:0]}, {18'd0, ei});
      end
      chk(nm, {18'd0, d[29:16]}, {18'd0, eq});
    end
  endtask : t_shot

  task automatic t_ema();
    wr(A_EMA, 32'h0000_0001);
    wr(A_CTRL, 32'h0000_00B0);
    t_shot(32'h0000_0092, 14'h0200, 14'h0000, 0, "ema first");
    big <= 1'b1;
    t_shot(32'h0000_0092, 14'h0300, 14'h0000, 0, "ema blend");
    wr(A_CTRL, 32'h0000_00B0);
    t_shot(32'h0000_0092, 14'h0400, 14'h0000, 0, "ema restart");
    big <= 1'b0;
    wr(A_CTRL, 32'h0000_0080);
  endtask : t_ema

  task automatic t_trig();
    logic [31:0] d;
    logic [1:0]  r;
    wr(A_CTRL, 32'h0000_0086);
    repeat (20) @(posedge aclk);
    rd(A_STAT, d, r);
    chk("armed state", {30'd0, d[1:0]}, 32'd1);
    chk("no early shot", {31'd0, irq}, 32'd0);
    trig_in <= 1'b1;
    @(posedge aclk);
    trig_in <= 1'b0;
    wait_shot();
    rd(A_STAT, d, r);
    chk("idle after single", {30'd0, d[1:0]}, 32'd0);
    rd(A_IRQ_STS, d, r);
    chk("stopped flag", {31'd0, d[I_STOPPED]}, 32'd1);
    wr(A_IRQ_STS, 32'h0000_0003);
    chk("irq cleared", {31'd0, irq}, 32'd0);
  endtask : t_trig

  task automatic t_run();
    logic [31:0] d, e, base;
    logic [1:0]  r;
    wr(A_IRQ_MSK, 32'h0000_0000);
    // earlier scenarios already counted shots, so judge the increase only
    rd(A_STAT, base, r);
    wr(A_CTRL, 32'h0000_0081);
    repeat (200) @(posedge aclk);
    rd(A_STAT, d, r);
    chk("shots repeat", {31'd0, d[31:16] - base[31:16] >= 16'd10}, 32'd1);
    chk("shot pace", {31'd0, d[31:16] - base[31:16] <= 16'd12}, 32'd1);
    chk("masked irq", {31'd0, irq}, 32'd0);
    wr(A_CTRL, 32'h0000_0080);
    repeat (100) @(posedge aclk);
    rd(A_STAT, d, r);
    repeat (50) @(posedge aclk);
    rd(A_STAT, e, r);
    chk("run stopped", e, d);
    chk("idle after run", {30'd0, e[1:0]}, 32'd0);
    rd_chk(A_IRQ_STS, 32'h0000_0003, "sticky done");
    wr(A_IRQ_STS, 32'h0000_0003);
  endtask : t_run

  // reset with decimation selected must bring back averaging and clear counters and flags
  task automatic t_rst_mid();
    wr(A_CTRL, 32'h0000_0088);
    rd_chk(A_CTRL, 32'h0000_0088, "decim selected");
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_chk(A_CTRL, 32'h0000_0080, "ctrl after reset");
    rd_chk(A_STAT, 32'h0000_0000, "stat after reset");
    rd_chk(A_IRQ_STS, 32'h0000_0000, "sts after reset");
  endtask : t_rst_mid

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    wr(A_LEN, 32'h0000_0004);
    wr(A_RATE, 32'h0000_0002);
    wr(A_IRQ_MSK, 32'h0000_0001);
    t_shot(32'h0000_0182, 14'h0200, 14'h3E00, 0, "avg in0 rf");
    t_shot(32'h0000_0082, 14'h0200, 14'h0000, 0, "avg in0");
    t_shot(32'h0000_00C2, 14'h0080, 14'h0000, 0, "avg in1");
    t_shot(32'h0000_008A, 14'h0100, 14'h0000, 1, "decim in0");
    t_ema();
    t_trig();
    t_run();
    t_rst_mid();
    end_sim();
  end
endmodule : testbench
`default_nettype wire
